// [src/flash_dev_end.sv]
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Quad enable turns third pin into data
// - Quad enable turns fourth pin into data
// - Otherwise select bit picks hold or reset
// - Hold with select low floats serial output
// - Hold pauses transfer, keeps partial sequence
// - Reset pin low resets and floats outputs
// - Master avoids reset during internal writes
// - Only clock modes zero and three
// - Sample inputs on serial clock rise
// - Change outputs on serial clock fall
// - Dual transfers turn lines zero, one around
// - Quad transfers use lines zero to three
// - Array split into 4 KB sectors
// - Sixteen and eight sectors form blocks
// - Select high ignores input, floats outputs
module flash_dev_end (
  flash_link_if.dev LINK,
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic PIN4_FUNCTION_SELECT_I,
  input wire flash_pkg::lane_mode_t LANE_MODE_I,
  input wire logic TX_EN_I,
  input wire logic [7:0] TX_BYTE_I,
  output logic TX_TAKE_O,
  output logic [7:0] RX_BYTE_O,
  output logic RX_VALID_O,
  output logic SELECTED_O,
  output logic HOLD_ACTIVE_O,
  output logic IN_RESET_O,
  output logic CLK_MODE3_O,
  input wire logic [23:0] ADDR_I,
  output logic [7:0] SECTOR_O,
  output logic [4:0] BLOCK32_O,
  output logic [3:0] BLOCK64_O
);

  // ==========================================================
  // Pin synchronisers
  logic cs_m_ff, cs_s_ff, cs_q_ff;
  logic sck_m_ff, sck_s_ff, sck_q_ff;
  logic [3:0] d_m_ff, d_s_ff;

  // Two flops per pin; the third stage only serves edge finding
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cs_m_ff <= 1'b1;
      cs_s_ff <= 1'b1;
      cs_q_ff <= 1'b1;
      sck_m_ff <= 1'b0;
      sck_s_ff <= 1'b0;
      sck_q_ff <= 1'b0;
      d_m_ff <= 4'hF;
      d_s_ff <= 4'hF;
    end else begin
      cs_m_ff <= LINK.cs_n;
      cs_s_ff <= cs_m_ff;
      cs_q_ff <= cs_s_ff;
      sck_m_ff <= LINK.sck;
      sck_s_ff <= sck_m_ff;
      sck_q_ff <= sck_s_ff;
      d_m_ff <= LINK.data_line;
      d_s_ff <= d_m_ff;
    end
  end

  // ==========================================================
  // Pin roles and link conditions
  logic sck_rise, sck_fall, cs_fall;
  logic pin4_hold, pin4_rst, hold_act, rst_act, active;
  logic [3:0] lanes, line_mask;
  logic sel_ok_ff, drive_ff;

  // Edges seen one to two clocks after the pin moves
  assign sck_rise = sck_s_ff & ~sck_q_ff;
  assign sck_fall = ~sck_s_ff & sck_q_ff;
  assign cs_fall = ~cs_s_ff & cs_q_ff;

  // Fourth pin is data under quad enable, else hold or reset
  assign pin4_hold = ~QUAD_ENABLE_BIT_I & ~PIN4_FUNCTION_SELECT_I;
  assign pin4_rst = ~QUAD_ENABLE_BIT_I & PIN4_FUNCTION_SELECT_I;
  assign hold_act = pin4_hold & ~d_s_ff[flash_pkg::LINE_P4] & ~cs_s_ff;
  assign rst_act = pin4_rst & ~d_s_ff[flash_pkg::LINE_P4];
  assign active = ~cs_s_ff & sel_ok_ff & ~rst_act;
  assign lanes = flash_pkg::lane_count(LANE_MODE_I);

  // Lines the device may drive in the current width
  always_comb begin
    case (LANE_MODE_I)
      flash_pkg::LANE_DUAL: line_mask = 4'h3;
      // Third and fourth pins only carry data under quad enable
      flash_pkg::LANE_QUAD: line_mask = {QUAD_ENABLE_BIT_I,
        QUAD_ENABLE_BIT_I, 2'h3};
      default: line_mask = 4'h2;
    endcase
  end

  // Drivers float on select high, hold or reset
  assign LINK.dev_oe_n = ~({4{drive_ff & active & ~hold_act}}
    & line_mask);

  // ==========================================================
  // Shift engine
  logic mode3_ff, nxt_mode3;
  logic nxt_sel_ok, nxt_drive;
  logic [7:0] rx_sh_ff, nxt_rx_sh, rx_byte_ff, nxt_rx_byte;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt;
  logic rx_valid_ff, nxt_rx_valid, tx_take_ff, nxt_tx_take;
  logic [7:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] do_ff, nxt_do;

  // Next values of the shift engine
  always_comb begin
    logic [7:0] src;
    src = TX_BYTE_I;
    nxt_sel_ok = sel_ok_ff;
    nxt_mode3 = mode3_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_byte = rx_byte_ff;
    nxt_rx_valid = 1'b0;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_take = 1'b0;
    nxt_do = do_ff;
    nxt_drive = drive_ff;
    if (rst_act) begin
      // A new select edge is needed after reset, as after power-up
      nxt_sel_ok = 1'b0;
      nxt_rx_cnt = 4'h0;
      nxt_tx_cnt = 4'h0;
      nxt_drive = 1'b0;
    end else if (cs_s_ff) begin
      nxt_sel_ok = 1'b1;
      nxt_rx_cnt = 4'h0;
      nxt_tx_cnt = 4'h0;
      nxt_drive = 1'b0;
    end else if (active && !hold_act) begin
      if (cs_fall) begin
        nxt_mode3 = sck_s_ff;
      end
      if (sck_rise) begin
        nxt_rx_sh = flash_pkg::shift_in(rx_sh_ff, d_s_ff, LANE_MODE_I,
          flash_pkg::LINE_IN);
        if (rx_cnt_ff + lanes == flash_pkg::BYTE_BITS) begin
          nxt_rx_byte = nxt_rx_sh;
          nxt_rx_valid = 1'b1;
          nxt_rx_cnt = 4'h0;
        end else begin
          nxt_rx_cnt = rx_cnt_ff + lanes;
        end
      end
      if (sck_fall) begin
        nxt_drive = TX_EN_I;
        if (TX_EN_I) begin
          if (tx_cnt_ff != 4'h0) begin
            src = tx_sh_ff;
          end else begin
            nxt_tx_take = 1'b1;
          end
          nxt_do = flash_pkg::out_bits(src, LANE_MODE_I,
            flash_pkg::LINE_OUT);
          nxt_tx_sh = flash_pkg::shift_out(src, LANE_MODE_I);
          if (tx_cnt_ff + lanes == flash_pkg::BYTE_BITS) begin
            nxt_tx_cnt = 4'h0;
          end else begin
            nxt_tx_cnt = tx_cnt_ff + lanes;
          end
        end
      end
    end
  end

  // Registers of the shift engine
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sel_ok_ff <= 1'b0;
      mode3_ff <= 1'b0;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 4'h0;
      rx_byte_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      tx_sh_ff <= 8'h00;
      tx_cnt_ff <= 4'h0;
      tx_take_ff <= 1'b0;
      do_ff <= 4'h0;
      drive_ff <= 1'b0;
    end else begin
      sel_ok_ff <= nxt_sel_ok;
      mode3_ff <= nxt_mode3;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_byte_ff <= nxt_rx_byte;
      rx_valid_ff <= nxt_rx_valid;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_take_ff <= nxt_tx_take;
      do_ff <= nxt_do;
      drive_ff <= nxt_drive;
    end
  end

  // ==========================================================
  // Array map decode
  logic [7:0] sector_ff, nxt_sector;
  logic [4:0] blk32_ff, nxt_blk32;
  logic [3:0] blk64_ff, nxt_blk64;

  // Bits above the top of the largest density are ignored
  always_comb begin
    nxt_sector = ADDR_I[flash_pkg::MAP_MSB:flash_pkg::SECT_LSB];
    nxt_blk32 = ADDR_I[flash_pkg::MAP_MSB:flash_pkg::B32_LSB];
    nxt_blk64 = ADDR_I[flash_pkg::MAP_MSB:flash_pkg::B64_LSB];
  end

  // Registered map outputs, one clock behind the address
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sector_ff <= 8'h00;
      blk32_ff <= 5'h00;
      blk64_ff <= 4'h0;
    end else begin
      sector_ff <= nxt_sector;
      blk32_ff <= nxt_blk32;
      blk64_ff <= nxt_blk64;
    end
  end

  // ==========================================================
  // Outputs
  assign LINK.dev_do = do_ff;
  assign TX_TAKE_O = tx_take_ff;
  assign RX_BYTE_O = rx_byte_ff;
  assign RX_VALID_O = rx_valid_ff;
  assign SELECTED_O = active;
  assign HOLD_ACTIVE_O = hold_act;
  assign IN_RESET_O = rst_act;
  assign CLK_MODE3_O = mode3_ff;
  assign SECTOR_O = sector_ff;
  assign BLOCK32_O = blk32_ff;
  assign BLOCK64_O = blk64_ff;

endmodule : flash_dev_end
`default_nettype wire

// [src/flash_pkg.sv]
package flash_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  // Cycles per half period of the serial clock made by the master
  localparam logic [3:0] HALF_CYC =
    4'(LINK_PERIOD_NS / CLK_PERIOD_NS / 2);

  // ==========================================================
  // Transfer width and line roles
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_t;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] LINE_IN = 2'h0;
  localparam logic [1:0] LINE_OUT = 2'h1;
  localparam int LINE_WP = 2;
  localparam int LINE_P4 = 3;

  // ==========================================================
  // Array map: 4 KB sectors, 32 KB and 64 KB blocks
  localparam int ADDR_W = 24;
  localparam int MAP_MSB = 19;
  localparam int SECT_LSB = 12;
  localparam int B32_LSB = 15;
  localparam int B64_LSB = 16;

  // ==========================================================
  // Master register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX = 4'h1;
  localparam logic [3:0] REG_RX = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam int CTRL_CS = 0;
  localparam int CTRL_MODE3 = 1;
  localparam int CTRL_LANE_LSB = 2;
  localparam int CTRL_LANE_MSB = 3;
  localparam int CTRL_DIR_IN = 4;
  localparam int CTRL_HOLD_N = 5;
  localparam int CTRL_RESET_N = 6;
  localparam int CTRL_WP_N = 7;
  localparam logic [7:0] CTRL_RST = 8'hE0;

  // ==========================================================
  // Shared lane arithmetic
  function automatic logic [3:0] lane_count(input lane_mode_t m);
    case (m)
      LANE_DUAL: return 4'h2;
      LANE_QUAD: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction : lane_count

  // Shift received bits in, MSB first; single mode uses line idx
  function automatic logic [7:0] shift_in(input logic [7:0] sh,
      input logic [3:0] d, input lane_mode_t m, input logic [1:0] idx);
    case (m)
      LANE_DUAL: return {sh[5:0], d[1:0]};
      LANE_QUAD: return {sh[3:0], d};
      default: return {sh[6:0], d[idx]};
    endcase
  endfunction : shift_in

  // Bits to present on the lines from the top of a shift register
  function automatic logic [3:0] out_bits(input logic [7:0] sh,
      input lane_mode_t m, input logic [1:0] idx);
    logic [3:0] r;
    r = 4'h0;
    case (m)
      LANE_DUAL: r = {2'h0, sh[7:6]};
      LANE_QUAD: r = sh[7:4];
      default: r[idx] = sh[7];
    endcase
    return r;
  endfunction : out_bits

  function automatic logic [7:0] shift_out(input logic [7:0] sh,
      input lane_mode_t m);
    case (m)
      LANE_DUAL: return {sh[5:0], 2'h0};
      LANE_QUAD: return {sh[3:0], 4'h0};
      default: return {sh[6:0], 1'b0};
    endcase
  endfunction : shift_out

endpackage : flash_pkg

// [src/flash_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] host_do;
  logic [3:0] host_oe_n;
  logic [3:0] dev_do;
  logic [3:0] dev_oe_n;
  logic [3:0] data_line;

  // ==========================================================
  // Wire resolution: device first, then master, else pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!dev_oe_n[i]) begin
        data_line[i] = dev_do[i];
      end else if (!host_oe_n[i]) begin
        data_line[i] = host_do[i];
      end else begin
        data_line[i] = 1'b1;
      end
    end
  end

  modport host (output sck, output cs_n, output host_do,
    output host_oe_n, input data_line);
  modport dev (input sck, input cs_n, input data_line,
    output dev_do, output dev_oe_n);
endinterface : flash_link_if
`default_nettype wire

// [src/flash_host_end.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_host_end (
  flash_link_if.host LINK,
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O
);

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} host_state_t;

  // ==========================================================
  // Data line synchroniser
  logic [3:0] d_m_ff, d_s_ff;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      d_m_ff <= 4'hF;
      d_s_ff <= 4'hF;
    end else begin
      d_m_ff <= LINK.data_line;
      d_s_ff <= d_m_ff;
    end
  end

  // ==========================================================
  // Control decode
  host_state_t state_ff, nxt_state;
  logic [7:0] ctrl_ff, nxt_ctrl;
  flash_pkg::lane_mode_t mode;
  logic [3:0] lanes;
  logic mode3, hold_n, busy, paused;

  assign mode = flash_pkg::lane_mode_t'(
    ctrl_ff[flash_pkg::CTRL_LANE_MSB:flash_pkg::CTRL_LANE_LSB]);
  assign lanes = flash_pkg::lane_count(mode);
  assign mode3 = ctrl_ff[flash_pkg::CTRL_MODE3];
  assign hold_n = ctrl_ff[flash_pkg::CTRL_HOLD_N];
  assign busy = state_ff != ST_IDLE;
  // Clock stops while hold is asserted outside quad width so no bit is lost
  assign paused = ~hold_n & (mode != flash_pkg::LANE_QUAD);

  // ==========================================================
  // Serial clock divider and byte engine
  logic [3:0] cnt_ff, nxt_cnt, bits_ff, nxt_bits;
  logic [7:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh;
  logic [7:0] rx_byte_ff, nxt_rx_byte, rdata_ff, nxt_rdata;
  logic [3:0] do_ff, nxt_do;
  logic sck_ff, nxt_sck;

  // Next values; a new bit starts with a falling serial clock
  always_comb begin
    nxt_state = state_ff;
    nxt_ctrl = ctrl_ff;
    nxt_cnt = cnt_ff;
    nxt_bits = bits_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_byte = rx_byte_ff;
    nxt_rdata = rdata_ff;
    nxt_do = do_ff;
    nxt_sck = sck_ff;
    if (WR_I && ADDR_I == flash_pkg::REG_CTRL) begin
      if (!busy) begin
        nxt_ctrl = WDATA_I;
      end else begin
        // Only the pause bit may move mid-byte, else a pause never ends
        nxt_ctrl[flash_pkg::CTRL_HOLD_N] =
          WDATA_I[flash_pkg::CTRL_HOLD_N];
      end
    end
    if (RD_I) begin
      case (ADDR_I)
        flash_pkg::REG_CTRL: nxt_rdata = ctrl_ff;
        flash_pkg::REG_TX: nxt_rdata = tx_sh_ff;
        flash_pkg::REG_RX: nxt_rdata = rx_byte_ff;
        flash_pkg::REG_STAT: nxt_rdata = {7'h00, busy};
        default: nxt_rdata = 8'h00;
      endcase
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_sck = mode3;
        if (WR_I && ADDR_I == flash_pkg::REG_TX
            && ctrl_ff[flash_pkg::CTRL_CS]) begin
          nxt_state = ST_LOW;
          nxt_cnt = 4'h0;
          nxt_bits = 4'h0;
          nxt_sck = 1'b0;
          nxt_do = flash_pkg::out_bits(WDATA_I, mode, flash_pkg::LINE_IN);
          nxt_tx_sh = flash_pkg::shift_out(WDATA_I, mode);
        end
      end
      ST_LOW: begin
        if (!paused) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == flash_pkg::HALF_CYC - 4'h1) begin
            nxt_state = ST_HIGH;
            nxt_cnt = 4'h0;
            nxt_sck = 1'b1;
          end
        end
      end
      ST_HIGH: begin
        if (!paused) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == flash_pkg::HALF_CYC - 4'h1) begin
            // Late capture covers the device's sync delay
            nxt_rx_sh = flash_pkg::shift_in(rx_sh_ff, d_s_ff, mode,
              flash_pkg::LINE_OUT);
            nxt_cnt = 4'h0;
            if (bits_ff + lanes == flash_pkg::BYTE_BITS) begin
              nxt_state = ST_IDLE;
              nxt_rx_byte = nxt_rx_sh;
              nxt_sck = mode3;
            end else begin
              nxt_state = ST_LOW;
              nxt_bits = bits_ff + lanes;
              nxt_sck = 1'b0;
              nxt_do = flash_pkg::out_bits(tx_sh_ff, mode,
                flash_pkg::LINE_IN);
              nxt_tx_sh = flash_pkg::shift_out(tx_sh_ff, mode);
            end
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Registers of the engine
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_ff <= ST_IDLE;
      ctrl_ff <= flash_pkg::CTRL_RST;
      cnt_ff <= 4'h0;
      bits_ff <= 4'h0;
      tx_sh_ff <= 8'h00;
      rx_sh_ff <= 8'h00;
      rx_byte_ff <= 8'h00;
      rdata_ff <= 8'h00;
      do_ff <= 4'h0;
      sck_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      cnt_ff <= nxt_cnt;
      bits_ff <= nxt_bits;
      tx_sh_ff <= nxt_tx_sh;
      rx_sh_ff <= nxt_rx_sh;
      rx_byte_ff <= nxt_rx_byte;
      rdata_ff <= nxt_rdata;
      do_ff <= nxt_do;
      sck_ff <= nxt_sck;
    end
  end

  // ==========================================================
  // Pin drive: data lines per width, side pins from control
  logic [3:0] data_mask;

  always_comb begin
    case (mode)
      flash_pkg::LANE_DUAL: data_mask = 4'h3;
      flash_pkg::LANE_QUAD: data_mask = 4'hF;
      default: data_mask = 4'h1;
    endcase
    if (ctrl_ff[flash_pkg::CTRL_DIR_IN]) begin
      data_mask = 4'h0;
    end
  end

  always_comb begin
    LINK.host_do = do_ff;
    LINK.host_oe_n = ~data_mask;
    if (mode != flash_pkg::LANE_QUAD) begin
      LINK.host_do[flash_pkg::LINE_WP] = ctrl_ff[flash_pkg::CTRL_WP_N];
      LINK.host_do[flash_pkg::LINE_P4] = hold_n
        & ctrl_ff[flash_pkg::CTRL_RESET_N];
      LINK.host_oe_n[flash_pkg::LINE_WP] = 1'b0;
      LINK.host_oe_n[flash_pkg::LINE_P4] = 1'b0;
    end
  end

  assign LINK.sck = sck_ff;
  assign LINK.cs_n = ~ctrl_ff[flash_pkg::CTRL_CS];
  assign RDATA_O = rdata_ff;

endmodule : flash_host_end
`default_nettype wire

// [testbench/flash_link_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Link checker on the wires shared by both ends
module flash_link_monitor (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_do,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] dev_do,
  input wire logic [3:0] dev_oe_n,
  input wire logic [3:0] data_line
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // Counts of four and five outlast the device's select synchroniser
  sequence pin4_low_s;
    !QUAD_ENABLE_BIT_I && !cs_n && !data_line[3];
  endsequence
  sequence pin4_held_s;
    pin4_low_s [*4];
  endsequence
  sequence desel_s;
    cs_n [*5];
  endsequence

  // ==========================================================
  // Idle, select and pin four behaviour
  a_reset_idle: assert property (
    $fell(SYS_RST_I) |-> cs_n && !sck && dev_oe_n == 4'hF)
    else $error("link not idle after reset");
  a_desel_float: assert property (
    desel_s |-> dev_oe_n == 4'hF)
    else $error("device drives while deselected");
  a_hold_float: assert property (
    pin4_held_s |-> dev_oe_n[1])
    else $error("device drives while paused or reset");
  a_no_clash: assert property (
    (~host_oe_n & ~dev_oe_n) == 4'h0)
    else $error("both ends drive one line");

  // ==========================================================
  // Serial clock phases and data timing
  a_sck_high: assert property (
    !cs_n && $rose(sck) |=> sck [*3])
    else $error("serial clock high phase too short");
  a_sck_low: assert property (
    !cs_n && $fell(sck) |=> !sck [*3])
    else $error("serial clock low phase too short");
  a_rise_stable: assert property (
    !cs_n && $rose(sck) |-> $stable(data_line[1:0]))
    else $error("data moved at serial clock rise");
  a_oe_on_low: assert property (
    $fell(dev_oe_n[1]) |-> !cs_n && !sck)
    else $error("device started driving outside low phase");
  a_change_low: assert property (
    !dev_oe_n[1] && $changed(dev_do) |-> !sck && !cs_n)
    else $error("device data changed outside low phase");
endmodule : flash_link_monitor
`default_nettype wire

// [testbench/serial_flash_pin_mux_and_map_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_flash_pin_mux_and_map_tb;
  typedef struct {
    logic [7:0] ctrl, tx, dtx;
    flash_pkg::lane_mode_t lm;
    logic qe, ten, chk_h, chk_d;
    logic [23:0] a;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] haddr, b64, oe;
  logic [7:0] wdata, rdata, txb, rxb, sect, dev_rx;
  logic [4:0] b32;
  logic wr, rd, qe, p7, txen, take, rxv, sel, hold, inrst, m3;
  logic [23:0] addr;
  flash_pkg::lane_mode_t lane;
  int fail_count = 0;
  int n_tests = 0;
  int dev_cnt = 0;
  int take_cnt = 0;
  // Reads start in mode 3: the first fall lets the device show bit 7
  row_t rows[6] = '{
    '{8'hE1, 8'hA5, 8'h00, flash_pkg::LANE_SINGLE, 0, 0, 0, 1, 24'h000000},
    '{8'hE3, 8'h81, 8'h7E, flash_pkg::LANE_SINGLE, 0, 1, 1, 1, 24'h00F000},
    '{8'hE5, 8'h96, 8'h00, flash_pkg::LANE_DUAL, 0, 0, 0, 1, 24'h010FFF},
    '{8'hF7, 8'h00, 8'h4B, flash_pkg::LANE_DUAL, 0, 1, 1, 0, 24'h07F123},
    '{8'hE9, 8'h5A, 8'h00, flash_pkg::LANE_QUAD, 1, 0, 0, 1, 24'h0FFFFF},
    '{8'hFB, 8'h00, 8'hC3, flash_pkg::LANE_QUAD, 1, 1, 1, 0, 24'hF30000}};

  flash_link_if i_flash_link_if();
  flash_host_end i_flash_host_end (.LINK(i_flash_link_if.host),
    .CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(haddr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
  flash_dev_end i_flash_dev_end (.LINK(i_flash_link_if.dev),
    .CLK_I(clk), .SYS_RST_I(rst), .QUAD_ENABLE_BIT_I(qe),
    .PIN4_FUNCTION_SELECT_I(p7), .LANE_MODE_I(lane), .TX_EN_I(txen),
    .TX_BYTE_I(txb), .TX_TAKE_O(take), .RX_BYTE_O(rxb),
    .RX_VALID_O(rxv), .SELECTED_O(sel), .HOLD_ACTIVE_O(hold),
    .IN_RESET_O(inrst), .CLK_MODE3_O(m3), .ADDR_I(addr),
    .SECTOR_O(sect), .BLOCK32_O(b32), .BLOCK64_O(b64));
  flash_link_monitor i_flash_link_monitor (.CLK_I(clk),
    .SYS_RST_I(rst), .QUAD_ENABLE_BIT_I(qe),
    .sck(i_flash_link_if.sck), .cs_n(i_flash_link_if.cs_n),
    .host_do(i_flash_link_if.host_do),
    .host_oe_n(i_flash_link_if.host_oe_n),
    .dev_do(i_flash_link_if.dev_do), .dev_oe_n(i_flash_link_if.dev_oe_n),
    .data_line(i_flash_link_if.data_line));
  assign oe = i_flash_link_if.dev_oe_n;

  // ==========================================================
  // Clock and capture of one-cycle device pulses
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (rxv === 1'b1) begin
      dev_rx <= rxb;
      dev_cnt <= dev_cnt + 1;
    end
    if (take === 1'b1) begin
      take_cnt <= take_cnt + 1;
    end
  end

  // ==========================================================
  // Register port and compare tasks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    haddr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    haddr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic chk8(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1
  // Polling is bounded so a stuck busy flag ends as a mismatch
  task automatic wait_idle;
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      rd_reg(flash_pkg::REG_STAT, s);
      if (s[0] === 1'b0) break;
    end
    chk1("busy", 1'b0, s[0]);
  endtask : wait_idle
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    #(20000 * 100);
    fail_count++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    int c0;
    int t0;
    {haddr, wdata, wr, rd, qe, p7, txen, txb, addr} = '0;
    lane = flash_pkg::LANE_SINGLE;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(flash_pkg::REG_RX, d);
    chk8("rx after reset", 8'h00, d);
    rd_reg(4'hF, d);
    chk8("unmapped", 8'h00, d);
    chk1("sel after reset", 1'b0, sel);
    // Table of transfers with the map decode alongside
    for (int r = 0; r < 6; r++) begin
      // Clock reaches the mode's idle level before select falls
      wr_reg(flash_pkg::REG_CTRL, rows[r].ctrl & 8'hFE);
      qe <= rows[r].qe;
      lane <= rows[r].lm;
      txen <= rows[r].ten;
      txb <= rows[r].dtx;
      addr <= rows[r].a;
      c0 = dev_cnt;
      t0 = take_cnt;
      wr_reg(flash_pkg::REG_CTRL, rows[r].ctrl);
      wr_reg(flash_pkg::REG_TX, rows[r].tx);
      repeat (2) @(posedge clk);
      wait_idle();
      rd_reg(flash_pkg::REG_RX, d);
      if (rows[r].chk_h) chk8("host rx", rows[r].dtx, d);
      if (rows[r].chk_d) chk8("dev rx", rows[r].tx, dev_rx);
      if (rows[r].chk_d) chk8("rx pulses", 8'h01, 8'(dev_cnt - c0));
      if (rows[r].ten) chk8("takes", 8'h01, 8'(take_cnt - t0));
      chk8("sector", rows[r].a[19:12], sect);
      chk8("block32", {3'h0, rows[r].a[19:15]}, {3'h0, b32});
      chk8("block64", {4'h0, rows[r].a[19:16]}, {4'h0, b64});
      chk1("mode3", rows[r].ctrl[1], m3);
      // Select rises before the lines change hands, so no two drivers
      wr_reg(flash_pkg::REG_CTRL, rows[r].ctrl & 8'hFE);
      settle();
      wr_reg(flash_pkg::REG_CTRL, flash_pkg::CTRL_RST);
    end
    // Pause one clock after the fourth bit's fall, once the device has
    // taken that fall and drives; the byte still arrives whole
    wr_reg(flash_pkg::REG_CTRL, flash_pkg::CTRL_RST);
    settle();
    qe <= 1'b0;
    lane <= flash_pkg::LANE_SINGLE;
    txen <= 1'b1;
    c0 = dev_cnt;
    wr_reg(flash_pkg::REG_CTRL, 8'hE1);
    wr_reg(flash_pkg::REG_TX, 8'h66);
    repeat (23) @(posedge clk);
    wr_reg(flash_pkg::REG_CTRL, 8'hC1);
    settle();
    chk1("hold", 1'b1, hold);
    chk1("out float", 1'b1, oe[1]);
    rd_reg(flash_pkg::REG_STAT, d);
    chk1("busy in pause", 1'b1, d[0]);
    wr_reg(flash_pkg::REG_CTRL, 8'hE1);
    repeat (2) @(posedge clk);
    wait_idle();
    chk8("held rx", 8'h66, dev_rx);
    chk8("held pulses", 8'h01, 8'(dev_cnt - c0));
    // Pin four as reset, then as data, then as pause
    wr_reg(flash_pkg::REG_CTRL, flash_pkg::CTRL_RST);
    settle();
    p7 <= 1'b1;
    wr_reg(flash_pkg::REG_CTRL, 8'hA1);
    settle();
    chk1("in reset", 1'b1, inrst);
    chk1("sel in reset", 1'b0, sel);
    chk8("reset float", 8'h0F, {4'h0, oe});
    @(posedge clk);
    qe <= 1'b1;
    settle();
    chk1("reset with qe", 1'b0, inrst);
    @(posedge clk);
    qe <= 1'b0;
    p7 <= 1'b0;
    settle();
    chk1("pause by p4", 1'b1, hold);
    chk1("no reset p4", 1'b0, inrst);
    // Leaving reset needs a fresh select fall
    p7 <= 1'b1;
    wr_reg(flash_pkg::REG_CTRL, 8'hE1);
    settle();
    chk1("sel no fall", 1'b0, sel);
    wr_reg(flash_pkg::REG_CTRL, flash_pkg::CTRL_RST);
    settle();
    chk8("desel float", 8'h0F, {4'h0, oe});
    give_verdict();
  end
endmodule : serial_flash_pin_mux_and_map_tb
`default_nettype wire
